// ==== core/cmlsb_alu.sv ====
`timescale 1ns/1ps
`include "cmlsb_consts.svh"

module cmlsb_alu
  import cmlsb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        mode16,
  input  wire logic        op_valid,
  input  wire logic [2:0]  op_code,
  input  wire logic [23:0] op_a,
  input  wire logic [23:0] op_b,
  output logic      [23:0] result,
  output logic             result_valid
);

  // Operand view: low 16 bits sign-extended in 16-bit mode
  function automatic logic signed [25:0] cmlsb_opnd(input logic [23:0] x, input logic m16);
    cmlsb_opnd = m16 ? 26'($signed(x[`CMLSB_W16-1:0])) : 26'($signed(x));
  endfunction

  // Limiting; 16-bit results sit right-justified with the upper byte clear
  function automatic logic [23:0] cmlsb_limit(input logic signed [25:0] v, input logic m16);
    logic signed [25:0] hi;
    logic signed [25:0] lo;
    hi = m16 ? `CMLSB_MAX16 : `CMLSB_MAX24;
    lo = m16 ? `CMLSB_MIN16 : `CMLSB_MIN24;
    if (v > hi) begin
      v = hi;
    end else if (v < lo) begin
      v = lo;
    end
    cmlsb_limit = m16 ? {8'h00, v[`CMLSB_W16-1:0]} : v[`CMLSB_W24-1:0];
  endfunction

  logic signed [25:0] a_s;
  logic signed [25:0] b_s;
  logic signed [25:0] raw;
  logic        [23:0] next_result;
  logic               next_result_valid;

  // Width-aware arithmetic, shifts and moves
  always_comb begin
    a_s = cmlsb_opnd(op_a, mode16);
    b_s = cmlsb_opnd(op_b, mode16);
    unique case (cmlsb_aluop_t'(op_code))
      CMLSB_OP_ADD: raw = a_s + b_s;
      CMLSB_OP_SUB: raw = a_s - b_s;
      CMLSB_OP_ASL: raw = a_s <<< 1;
      CMLSB_OP_ASR: raw = a_s >>> 1;
      default:      raw = a_s;                          // Move and unused codes
    endcase
    next_result       = result;
    next_result_valid = 1'b0;
    if (op_valid) begin
      next_result       = cmlsb_limit(raw, mode16);
      next_result_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      result       <= 24'h00_0000;
      result_valid <= 1'b0;
    end else if (ce) begin
      result       <= next_result;
      result_valid <= next_result_valid;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_m16_upper_clear: assert property (ce && op_valid && mode16 |=> result[23:16] == 8'h00)
    else $error("16-bit result not right-justified");
  a_m16_add_value: assert property (ce && op_valid && mode16 && op_code == CMLSB_OP_ADD
      && op_a == 24'h00_0001 && op_b == 24'h00_0001 |=> result == 24'h00_0002)
    else $error("16-bit add result wrong");

endmodule

// ==== core/cmlsb_status.sv ====
`timescale 1ns/1ps
`include "cmlsb_consts.svh"

module cmlsb_status
  import cmlsb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        loop_begin,
  input  wire logic        loop_is_forever,
  input  wire logic        loop_exit,
  input  wire logic        return_from_interrupt_instr,
  input  wire logic        stack_lf_in,
  input  wire logic        stack_fv_in,
  output logic             stack_push,
  output logic             stack_lf_out,
  output logic             stack_fv_out,
  output logic             sixteen_bit_arith_mode,
  output logic             double_prec_multiply_mode,
  output logic             loop_active_flag,
  output logic             forever_loop_flag,
  output logic             loop_end_detect_en,
  input  wire logic        alu_valid,
  input  wire logic [2:0]  alu_op,
  input  wire logic [23:0] alu_a,
  input  wire logic [23:0] alu_b,
  output logic [23:0]      alu_result,
  output logic             alu_result_valid,
  input  wire logic        mul_valid,
  input  wire logic [1:0]  mul_stage,
  input  wire logic        mul_designated,
  input  wire logic [23:0] mul_a,
  input  wire logic [23:0] mul_b,
  output logic [47:0]      mul_product,
  output logic             mul_done
);

  // Status word image as software sees it; reserved bit reads zero
  function automatic logic [31:0] cmlsb_word(input logic sa, input logic fv, input logic lf, input logic dm);
    cmlsb_word = 32'h0000_0000;
    cmlsb_word[`CMLSB_BIT_SA] = sa;
    cmlsb_word[`CMLSB_BIT_FV] = fv;
    cmlsb_word[`CMLSB_BIT_LF] = lf;
    cmlsb_word[`CMLSB_BIT_DM] = dm;
  endfunction

  cmlsb_wr_state_t wr_state;
  cmlsb_wr_state_t next_wr_state;
  logic            aw_held;
  logic            w_held;
  logic [3:0]      wr_addr;
  logic [31:0]     wr_data;
  logic [3:0]      wr_strb;
  logic            next_aw_held;
  logic            next_w_held;
  logic [3:0]      next_wr_addr;
  logic [31:0]     next_wr_data;
  logic [3:0]      next_wr_strb;
  logic [1:0]      next_bresp;
  logic            wr_fire;
  cmlsb_rd_state_t rd_state;
  cmlsb_rd_state_t next_rd_state;
  logic [31:0]     next_rdata;
  logic [1:0]      next_rresp;
  logic            next_sa;
  logic            next_dm;
  logic            next_lf;
  logic            next_fv;
  logic            next_push;
  logic            next_push_lf;
  logic            next_push_fv;
  logic [47:0]     next_product;
  logic            next_mul_done;

  // Address, data and read-address readies gated by ce so no request is taken while frozen; bvalid and rvalid are not gated
  assign s_axi_awready = ce && (wr_state == CMLSB_WR_COLLECT) && !aw_held;
  assign s_axi_wready  = ce && (wr_state == CMLSB_WR_COLLECT) && !w_held;
  assign s_axi_bvalid  = (wr_state == CMLSB_WR_RESP);
  assign s_axi_arready = ce && (rd_state == CMLSB_RD_IDLE);
  assign s_axi_rvalid  = (rd_state == CMLSB_RD_DATA);
  assign loop_end_detect_en = loop_active_flag;

  // Write channel: address and data in either order, response after both
  always_comb begin
    next_wr_state = wr_state;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_wr_strb  = wr_strb;
    next_bresp    = s_axi_bresp;
    wr_fire       = 1'b0;
    unique case (wr_state)
      CMLSB_WR_COLLECT: begin
        if (s_axi_awvalid && s_axi_awready) begin
          next_aw_held = 1'b1;
          next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          next_w_held  = 1'b1;
          next_wr_data = s_axi_wdata;
          next_wr_strb = s_axi_wstrb;
        end
        if (next_aw_held && next_w_held) begin
          wr_fire       = 1'b1;
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
          next_wr_state = CMLSB_WR_RESP;
          next_bresp    = (next_wr_addr == `CMLSB_ADDR_STATUS) ? `CMLSB_RESP_OKAY : `CMLSB_RESP_DECERR;
        end
      end
      CMLSB_WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = CMLSB_WR_COLLECT;
        end
      end
    endcase
  end

  // Read channel: one register, decode error elsewhere
  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    unique case (rd_state)
      CMLSB_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_rd_state = CMLSB_RD_DATA;
          if (s_axi_araddr == `CMLSB_ADDR_STATUS) begin
            next_rdata = cmlsb_word(sixteen_bit_arith_mode, forever_loop_flag,
                                    loop_active_flag, double_prec_multiply_mode);
            next_rresp = `CMLSB_RESP_OKAY;
          end else begin
            next_rdata = 32'h0000_0000;
            next_rresp = `CMLSB_RESP_DECERR;
          end
        end
      end
      CMLSB_RD_DATA: begin
        if (s_axi_rready) begin
          next_rd_state = CMLSB_RD_IDLE;
        end
      end
    endcase
  end

  // Mode bits from software; loop flags only from the sequencer.
  // Loop entry beats a same-cycle restore: the new loop must nest on top.
  always_comb begin
    next_sa      = sixteen_bit_arith_mode;
    next_dm      = double_prec_multiply_mode;
    next_lf      = loop_active_flag;
    next_fv      = forever_loop_flag;
    next_push    = 1'b0;
    next_push_lf = stack_lf_out;
    next_push_fv = stack_fv_out;
    if (wr_fire && next_wr_addr == `CMLSB_ADDR_STATUS) begin
      if (next_wr_strb[`CMLSB_LANE_SA]) begin
        next_sa = next_wr_data[`CMLSB_BIT_SA];
      end
      if (next_wr_strb[`CMLSB_LANE_DM]) begin
        next_dm = next_wr_data[`CMLSB_BIT_DM];
      end
    end
    if (loop_begin) begin
      next_push    = 1'b1;
      next_push_lf = loop_active_flag;
      next_push_fv = forever_loop_flag;
      next_lf      = 1'b1;
      next_fv      = loop_is_forever;
    end else if (loop_exit || return_from_interrupt_instr) begin
      next_lf = stack_lf_in;
      next_fv = stack_fv_in;
    end
  end

  // Multiply stages; only designated combinations change in DM mode
  always_comb begin
    logic signed [24:0] ax;
    logic signed [24:0] bx;
    logic signed [49:0] p;
    ax = 25'($signed(mul_a));
    bx = 25'($signed(mul_b));
    p  = 50'(ax * bx);
    next_product  = mul_product;
    next_mul_done = 1'b0;
    if (mul_valid) begin
      next_mul_done = 1'b1;
      if (double_prec_multiply_mode && mul_designated) begin
        ax = mul_stage[0] ? 25'($signed(mul_a)) : {1'b0, mul_a};
        bx = mul_stage[1] ? 25'($signed(mul_b)) : {1'b0, mul_b};
        p  = 50'(ax * bx);
        next_product = p[47:0];                           // Integer partial product
      end else begin
        next_product = {p[46:0], 1'b0};                   // Fractional as normal
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_state                  <= CMLSB_WR_COLLECT;
      aw_held                   <= 1'b0;
      w_held                    <= 1'b0;
      wr_addr                   <= 4'h0;
      wr_data                   <= 32'h0000_0000;
      wr_strb                   <= 4'h0;
      s_axi_bresp               <= `CMLSB_RESP_OKAY;
      rd_state                  <= CMLSB_RD_IDLE;
      s_axi_rdata               <= 32'h0000_0000;
      s_axi_rresp               <= `CMLSB_RESP_OKAY;
      sixteen_bit_arith_mode    <= `CMLSB_RST_SA;
      double_prec_multiply_mode <= `CMLSB_RST_DM;
      loop_active_flag          <= `CMLSB_RST_LF;
      forever_loop_flag         <= `CMLSB_RST_FV;
      stack_push                <= 1'b0;
      stack_lf_out              <= 1'b0;
      stack_fv_out              <= 1'b0;
      mul_product               <= 48'h0000_0000_0000;
      mul_done                  <= 1'b0;
    end else if (ce) begin
      wr_state                  <= next_wr_state;
      aw_held                   <= next_aw_held;
      w_held                    <= next_w_held;
      wr_addr                   <= next_wr_addr;
      wr_data                   <= next_wr_data;
      wr_strb                   <= next_wr_strb;
      s_axi_bresp               <= next_bresp;
      rd_state                  <= next_rd_state;
      s_axi_rdata               <= next_rdata;
      s_axi_rresp               <= next_rresp;
      sixteen_bit_arith_mode    <= next_sa;
      double_prec_multiply_mode <= next_dm;
      loop_active_flag          <= next_lf;
      forever_loop_flag         <= next_fv;
      stack_push                <= next_push;
      stack_lf_out              <= next_push_lf;
      stack_fv_out              <= next_push_fv;
      mul_product               <= next_product;
      mul_done                  <= next_mul_done;
    end
  end

  // Width-selectable datapath
  cmlsb_alu u_alu (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .ce           (ce),
    .mode16       (sixteen_bit_arith_mode),
    .op_valid     (alu_valid),
    .op_code      (alu_op),
    .op_a         (alu_a),
    .op_b         (alu_b),
    .result       (alu_result),
    .result_valid (alu_result_valid)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_begin;
    ce && loop_begin;
  endsequence
  sequence s_restore;
    ce && !loop_begin && (loop_exit || return_from_interrupt_instr);
  endsequence

  a_begin_sets_lf: assert property (s_begin |=> loop_active_flag && loop_end_detect_en)
    else $error("loop flag not set at loop entry");
  a_forever_sets_fv: assert property (s_begin ##0 loop_is_forever |=> forever_loop_flag)
    else $error("forever flag not set");
  a_begin_pushes: assert property (s_begin |=> stack_push && stack_lf_out == $past(loop_active_flag)
      && stack_fv_out == $past(forever_loop_flag))
    else $error("flags not pushed at loop entry");
  a_restore_flags: assert property (s_restore |=> loop_active_flag == $past(stack_lf_in)
      && forever_loop_flag == $past(stack_fv_in))
    else $error("flags not restored from stack");
  a_sa_write: assert property (ce && wr_fire && next_wr_addr == `CMLSB_ADDR_STATUS
      && next_wr_strb[`CMLSB_LANE_SA] |=> sixteen_bit_arith_mode == $past(next_wr_data[`CMLSB_BIT_SA]))
    else $error("mode bit write lost");
  a_flags_bus_safe: assert property (ce && !loop_begin && !loop_exit && !return_from_interrupt_instr
      |=> $stable(loop_active_flag) && $stable(forever_loop_flag))
    else $error("loop flag changed without sequencer");
  a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[`CMLSB_BIT_RSVD] == 1'b0)
    else $error("reserved bit reads nonzero");
  a_dm_uu_stage: assert property (ce && mul_valid && double_prec_multiply_mode && mul_designated
      && mul_stage == 2'b00 && mul_a == 24'hff_ffff && mul_b == 24'h00_0002
      |=> mul_product == 48'h0000_01ff_fffe)
    else $error("double-precision stage product wrong");
  a_normal_mult: assert property (ce && mul_valid && !mul_designated && mul_a == 24'h40_0000
      && mul_b == 24'h40_0000 |=> mul_product == 48'h2000_0000_0000)
    else $error("normal multiply changed");

endmodule

// ==== shared/cmlsb_consts.svh ====
`ifndef CMLSB_CONSTS_SVH
`define CMLSB_CONSTS_SVH

// Register byte addresses
`define CMLSB_ADDR_STATUS   4'h0

// Status word field positions
`define CMLSB_BIT_RSVD      18
`define CMLSB_BIT_SA        17
`define CMLSB_BIT_FV        16
`define CMLSB_BIT_LF        15
`define CMLSB_BIT_DM        14

// Byte lanes holding the writable mode bits
`define CMLSB_LANE_SA       2
`define CMLSB_LANE_DM       1

// Reset values of the status bits
`define CMLSB_RST_SA        1'b0
`define CMLSB_RST_FV        1'b0
`define CMLSB_RST_LF        1'b0
`define CMLSB_RST_DM        1'b0

// Bus responses
`define CMLSB_RESP_OKAY     2'b00
`define CMLSB_RESP_DECERR   2'b11

// Limiting bounds, 16-bit and 24-bit
`define CMLSB_MAX16         26'sh000_7fff
`define CMLSB_MIN16         -26'sh000_8000
`define CMLSB_MAX24         26'sh07f_ffff
`define CMLSB_MIN24         -26'sh080_0000

// Widths
`define CMLSB_W16           16
`define CMLSB_W24           24

`endif

// ==== shared/cmlsb_pkg.sv ====
package cmlsb_pkg;

  typedef enum logic [1:0] {
    CMLSB_WR_COLLECT = 2'b01,
    CMLSB_WR_RESP    = 2'b10
  } cmlsb_wr_state_t;

  typedef enum logic [1:0] {
    CMLSB_RD_IDLE = 2'b01,
    CMLSB_RD_DATA = 2'b10
  } cmlsb_rd_state_t;

  typedef enum logic [2:0] {
    CMLSB_OP_MOVE = 3'h0,
    CMLSB_OP_ADD  = 3'h1,
    CMLSB_OP_SUB  = 3'h2,
    CMLSB_OP_ASL  = 3'h3,
    CMLSB_OP_ASR  = 3'h4
  } cmlsb_aluop_t;

endpackage

// ==== verif/cmlsb_tb_top.sv ====
`timescale 1ns/1ps
`include "cmlsb_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module cmlsb_tb_top
  import cmlsb_pkg::*;
;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, ce = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        loop_begin = 1'b0, loop_is_forever = 1'b0, loop_exit = 1'b0;
  logic        return_from_interrupt_instr = 1'b0, stack_lf_in = 1'b0, stack_fv_in = 1'b0;
  logic        alu_valid = 1'b0, mul_valid = 1'b0, mul_designated = 1'b0;
  logic [2:0]  alu_op = 3'h0;
  logic [1:0]  mul_stage = 2'h0;
  logic [23:0] alu_a = 24'h00_0000, alu_b = 24'h00_0000, mul_a = 24'h00_0000, mul_b = 24'h00_0000;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        stack_push, stack_lf_out, stack_fv_out, sixteen_bit_arith_mode;
  logic        double_prec_multiply_mode, loop_active_flag, forever_loop_flag, loop_end_detect_en;
  logic [23:0] alu_result;
  logic        alu_result_valid, mul_done;
  logic [47:0] mul_product;
  int          checks = 0;
  int          fails = 0;

  cmlsb_status i_cmlsb_status (
    .ref_clk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .loop_begin, .loop_is_forever, .loop_exit, .return_from_interrupt_instr,
    .stack_lf_in, .stack_fv_in, .stack_push, .stack_lf_out, .stack_fv_out, .sixteen_bit_arith_mode,
    .double_prec_multiply_mode, .loop_active_flag, .forever_loop_flag, .loop_end_detect_en,
    .alu_valid, .alu_op, .alu_a, .alu_b, .alu_result, .alu_result_valid, .mul_valid, .mul_stage,
    .mul_designated, .mul_a, .mul_b, .mul_product, .mul_done
  );

  // Free-running core clock
  always #5 ref_clk = ~ref_clk;

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Write: ready is sampled 1 ns after an edge, since it cannot change before the next one
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int         n;
    logic       pa, pw, ta, tw, tb;
    logic [1:0] rsp;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    tb = 1'b0;
    for (n = 0; n < 20 && !tb; n++) begin
      #1;
      ta = pa & (s_axi_awready === 1'b1);
      tw = pw & (s_axi_wready === 1'b1);
      tb = !pa & !pw & (s_axi_bvalid === 1'b1);
      rsp = s_axi_bresp;
      @(posedge ref_clk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    if (!tb) begin
      fails++;
      conclude();
    end
    `CHK("bresp", er, rsp)
  endtask

  // Read with rready held until the answer is taken
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int          n;
    logic        pa, ta, tr;
    logic [31:0] d;
    logic [1:0]  rsp;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    pa = 1'b1;
    tr = 1'b0;
    for (n = 0; n < 20 && !tr; n++) begin
      #1;
      ta = pa & (s_axi_arready === 1'b1);
      tr = !pa & (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge ref_clk);
      if (ta) begin
        s_axi_arvalid <= 1'b0;
        pa = 1'b0;
      end
    end
    s_axi_rready <= 1'b0;
    if (!tr) begin
      fails++;
      conclude();
    end
    `CHK("rresp", er, rsp)
    `CHK("rdata", ed, d)
  endtask

  // One ALU operation, result awaited under a bound
  task automatic alu(input logic [2:0] op, input logic [23:0] a, b, e);
    int   n;
    logic ok;
    @(posedge ref_clk);
    alu_valid <= 1'b1;
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge ref_clk);
      alu_valid <= 1'b0;
      #1;
      ok = (alu_result_valid === 1'b1);
    end
    if (!ok) begin
      fails++;
      conclude();
    end
    `CHK("alu_result", e, alu_result)
  endtask

  // One multiply stage
  task automatic mul(input logic [23:0] a, b, input logic [1:0] st, input logic dsg, input logic [47:0] e);
    int   n;
    logic ok;
    @(posedge ref_clk);
    mul_valid <= 1'b1;
    mul_a <= a;
    mul_b <= b;
    mul_stage <= st;
    mul_designated <= dsg;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge ref_clk);
      mul_valid <= 1'b0;
      #1;
      ok = (mul_done === 1'b1);
    end
    if (!ok) begin
      fails++;
      conclude();
    end
    `CHK("mul_product", e, mul_product)
  endtask

  // Sequencer event pulse; flags and push land one cycle later
  task automatic seq(input logic b, f, x, r, li, fi, elf, efv, input logic [1:0] eso);
    @(posedge ref_clk);
    loop_begin <= b;
    loop_is_forever <= f;
    loop_exit <= x;
    return_from_interrupt_instr <= r;
    stack_lf_in <= li;
    stack_fv_in <= fi;
    @(posedge ref_clk);
    loop_begin <= 1'b0;
    loop_exit <= 1'b0;
    return_from_interrupt_instr <= 1'b0;
    #1;
    `CHK("loop_active_flag", elf, loop_active_flag)
    `CHK("forever_loop_flag", efv, forever_loop_flag)
    `CHK("loop_end_detect_en", elf, loop_end_detect_en)
    `CHK("stack_push", b, stack_push)
    if (b)
      `CHK("stack_out", eso, {stack_lf_out, stack_fv_out})
    @(posedge ref_clk);
    #1;
    `CHK("stack_push_end", 1'b0, stack_push)
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(4'h0, 32'h0000_0000, `CMLSB_RESP_OKAY);
    // Every writable bit set, but the reserved bit is kept at zero as software must
    wr(4'h0, 32'hFFFB_FFFF, 4'hF, `CMLSB_RESP_OKAY);
    rd(4'h0, 32'h0002_4000, `CMLSB_RESP_OKAY);
    `CHK("sa", 1'b1, sixteen_bit_arith_mode)
    `CHK("dm", 1'b1, double_prec_multiply_mode)
    wr(4'h0, 32'h0000_0000, 4'hB, `CMLSB_RESP_OKAY);
    rd(4'h0, 32'h0002_0000, `CMLSB_RESP_OKAY);
    alu(CMLSB_OP_ADD, 24'h00_7FFF, 24'h00_0001, 24'h00_7FFF);
    alu(CMLSB_OP_MOVE, 24'hAB_1234, 24'h00_0000, 24'h00_1234);
    alu(CMLSB_OP_SUB, 24'h00_8000, 24'h00_0001, 24'h00_8000);
    alu(CMLSB_OP_ASR, 24'h00_8000, 24'h00_0000, 24'h00_C000);
    alu(CMLSB_OP_ASL, 24'h00_4000, 24'h00_0000, 24'h00_7FFF);
    alu(CMLSB_OP_ADD, 24'h00_0001, 24'h00_0001, 24'h00_0002);
    wr(4'h0, 32'h0000_4000, 4'hF, `CMLSB_RESP_OKAY);
    alu(CMLSB_OP_ADD, 24'h7F_FFFF, 24'h00_0001, 24'h7F_FFFF);
    alu(CMLSB_OP_MOVE, 24'hAB_1234, 24'h00_0000, 24'hAB_1234);
    mul(24'hFF_FFFF, 24'h00_0002, 2'b00, 1'b1, 48'h0000_01FF_FFFE);
    mul(24'hFF_FFFF, 24'h80_0000, 2'b01, 1'b1, 48'hFFFF_FF80_0000);
    // Operand a is taken unsigned only when stage bit 0 is clear, and stays put over all four stages
    mul(24'hFF_FFFF, 24'hFF_FFFF, 2'b10, 1'b1, 48'hFFFF_FF00_0001);
    mul(24'hFF_FFFF, 24'h00_0002, 2'b11, 1'b1, 48'hFFFF_FFFF_FFFE);
    mul(24'h40_0000, 24'h40_0000, 2'b11, 1'b0, 48'h2000_0000_0000);
    wr(4'h0, 32'h0000_0000, 4'hF, `CMLSB_RESP_OKAY);
    mul(24'h40_0000, 24'h40_0000, 2'b00, 1'b1, 48'h2000_0000_0000);
    seq(1, 1, 0, 0, 0, 0, 1, 1, 2'b00);
    seq(1, 0, 0, 0, 0, 0, 1, 0, 2'b11);
    rd(4'h0, 32'h0000_8000, `CMLSB_RESP_OKAY);
    seq(0, 0, 1, 0, 1, 1, 1, 1, 2'b00);
    wr(4'h0, 32'h0000_0000, 4'hF, `CMLSB_RESP_OKAY);
    rd(4'h0, 32'h0001_8000, `CMLSB_RESP_OKAY);
    seq(0, 0, 0, 1, 0, 0, 0, 0, 2'b00);
    seq(1, 1, 1, 0, 0, 0, 1, 1, 2'b00);
    // Clock enable low: a loop exit must not restore anything while frozen
    ce <= 1'b0;
    seq(0, 0, 1, 0, 0, 0, 1, 1, 2'b00);
    @(posedge ref_clk);
    ce <= 1'b1;
    wr(4'h4, 32'hFFFF_FFFF, 4'hF, `CMLSB_RESP_DECERR);
    rd(4'h4, 32'h0000_0000, `CMLSB_RESP_DECERR);
    rd(4'h0, 32'h0001_8000, `CMLSB_RESP_OKAY);
    conclude();
  end
endmodule
